// ==== dv/gcs_host_model.sv ====
// host model issuing one decoded register access at a time
`timescale 1ns/100ps
module gcs_host_model
  import gcs_pkg::*;
(
  input wire logic ref_clk,
  output gcs_access_t acc,
  input wire logic [7:0] rd_data_q,
  input wire logic rd_valid_q
);
  initial acc = '0;

  // spi command byte is w/r, two channel bits, five address bits
  task automatic xfer(input logic w, input logic i2c, input logic [1:0] ch,
                      input logic [6:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    gcs_access_t r;
    int n;
    r = '{1'b1, w, i2c, ch, a, {w, ch, a[4:0]}, d};
    q = 8'hxx;
    @(posedge ref_clk);
    acc <= r;
    @(posedge ref_clk);
    // released fields show the inverse so stale values never match
    acc <= {1'b0, ~r[26:0]};
    for (n = 0; n < 4 && !w; n++)
    begin
      @(posedge ref_clk);
      if (rd_valid_q === 1'b1)
      begin
        q = rd_data_q;
        break;
      end
    end
  endtask : xfer
endmodule : gcs_host_model

// ==== dv/gcs_tb.sv ====
// directed testbench for the global command and launch control block
`timescale 1ns/100ps
module tb
  import gcs_pkg::*;
;
  localparam logic [7:0] REV = 8'h3c; // arbitrary value
  logic ref_clk, rst_n, rd_valid_q, ext_addr_q, global_cmd_valid_q, tick_on;
  gcs_access_t acc;
  logic [3:0] irq_n, bit_tick, queue_has_data, tx_idle, tx_line, frac_clk;
  logic [3:0] transmitter_off_q, launch_q, start_seen_q, gpio_clk_q, gpio_oe_q;
  logic [7:0] rd_data_q, global_cmd_q, q;
  logic [2:0] div;
  int bad_count, check_count, n, ticks;

  gcs_top #(.REVISION(REV)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .acc(acc), .irq_n(irq_n), .bit_tick(bit_tick),
    .queue_has_data(queue_has_data), .tx_idle(tx_idle), .tx_line(tx_line),
    .frac_clk(frac_clk), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
    .ext_addr_q(ext_addr_q), .global_cmd_q(global_cmd_q),
    .global_cmd_valid_q(global_cmd_valid_q),
    .transmitter_off_q(transmitter_off_q), .launch_q(launch_q),
    .start_seen_q(start_seen_q), .gpio_clk_q(gpio_clk_q),
    .gpio_oe_q(gpio_oe_q));
  gcs_host_model host (.ref_clk(ref_clk), .acc(acc),
    .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q));

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // divider clock toggles freely; bit ticks only while a delay is timed
  always @(posedge ref_clk)
  begin
    frac_clk <= ~frac_clk;
    div <= div + 3'h1;
    bit_tick <= {4{tick_on && div == 3'h7}};
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask : chk

  task automatic wr(input logic [1:0] ch, input logic [6:0] a,
                    input logic [7:0] d);
    host.xfer(1'b1, 1'b1, ch, a, d, q);
  endtask : wr

  task automatic rd(input logic m, input logic [1:0] ch, input logic [6:0] a,
                    input logic [7:0] e);
    host.xfer(1'b0, m, ch, a, 8'h00, q);
    chk(q, e);
  endtask : rd

  // watch one output bit for four edges and compare whether it went high
  task automatic see(input int k, input int ch, input logic e);
    logic got;
    logic [3:0] v;
    got = 1'b0;
    repeat (4)
    begin
      @(posedge ref_clk);
      v = k == 0 ? launch_q : k == 1 ? start_seen_q : k == 2 ?
          transmitter_off_q : k == 3 ? {4{ext_addr_q}} : k == 4 ?
          gpio_oe_q : gpio_clk_q;
      got = got | (v[ch] === 1'b1);
    end
    chk({7'h0, got}, {7'h0, e});
  endtask : see

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  initial
  begin
    #50000;
    bad_count++;
    give_verdict();
  end

  initial
  begin
    rst_n = 1'b0;
    irq_n = 4'hf;
    queue_has_data = 4'hf;
    tx_idle = 4'hf;
    tx_line = 4'hf;
    frac_clk = 4'h0;
    div = 3'h0;
    tick_on = 1'b0;
    bad_count = 0;
    check_count = 0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(1'b1, 2'd0, 7'h20, 8'h00);
    rd(1'b1, 2'd2, 7'h25, REV);
    wr(2'd1, 7'h21, 8'ha5);
    rd(1'b1, 2'd1, 7'h21, 8'ha5);
    rd(1'b1, 2'd2, 7'h21, 8'h00);
    wr(2'd3, 7'h22, 8'h3c);
    rd(1'b1, 2'd3, 7'h22, 8'h3c);
    irq_n <= 4'h9;
    rd(1'b1, 2'd1, 7'h1f, 8'h09);
    // spi enters extended space; a4 is ignored there
    host.xfer(1'b1, 1'b0, 2'd0, 7'h1f, 8'hce, q);
    see(3, 0, 1'b1);
    rd(1'b0, 2'd1, 7'h11, 8'ha5);
    rd(1'b0, 2'd3, 7'h02, 8'h3c);
    wr(2'd0, 7'h1f, 8'he5);
    see(3, 0, 1'b1);
    wr(2'd0, 7'h1f, 8'hcd);
    see(3, 0, 1'b0);
    chk(global_cmd_q, 8'hcd);
    rd(1'b0, 2'd1, 7'h01, 8'h00);
    for (n = 0; n < 16; n++)
    begin
      wr(2'd1, 7'h20, 8'h10 | n[7:0]);
      see(2, 1, 1'b1);
      wr(2'd0, 7'h1f, 8'he0 | ((n[7:0] + 8'h01) & 8'h0f));
      see(0, 1, 1'b0);
      wr(2'd0, 7'h1f, 8'he0 | n[7:0]);
      see(0, 1, 1'b1);
      see(2, 1, 1'b0);
    end
    wr(2'd2, 7'h20, 8'h08);
    wr(2'd0, 7'h1f, 8'he8);
    see(0, 2, 1'b0);
    queue_has_data <= 4'he;
    wr(2'd0, 7'h20, 8'h18);
    wr(2'd0, 7'h1f, 8'he8);
    see(0, 0, 1'b0);
    // ticks are counted from the trigger until the launch pulse
    wr(2'd3, 7'h21, 8'h03);
    wr(2'd3, 7'h22, 8'h00);
    wr(2'd3, 7'h20, 8'h30);
    wr(2'd0, 7'h1f, 8'he0);
    tick_on <= 1'b1;
    ticks = 0;
    for (n = 0; n < 60 && launch_q[3] !== 1'b1; n++)
    begin
      @(posedge ref_clk);
      ticks = ticks + int'(bit_tick[3] === 1'b1);
    end
    tick_on <= 1'b0;
    chk(ticks[7:0], 8'h03);
    wr(2'd3, 7'h21, 8'h00);
    wr(2'd3, 7'h20, 8'h30);
    wr(2'd0, 7'h1f, 8'he0);
    see(0, 3, 1'b1);
    // shutoff must wait for the shifter to go idle as well
    queue_has_data <= 4'hb;
    tx_idle <= 4'hb;
    wr(2'd2, 7'h20, 8'h40);
    tx_line <= 4'hb;
    see(1, 2, 1'b1);
    tx_line <= 4'hf;
    see(2, 2, 1'b0);
    tx_idle <= 4'hf;
    see(2, 2, 1'b1);
    wr(2'd0, 7'h20, 8'h80);
    see(4, 0, 1'b1);
    see(4, 1, 1'b0);
    see(5, 0, 1'b1);
    see(5, 1, 1'b0);
    give_verdict();
  end
endmodule : tb

// ==== dv/gcs_top_sva.sv ====
// concurrent checks on the ports of the launch control block
`timescale 1ns/100ps
module gcs_top_sva
  import gcs_pkg::*;
#(
  parameter int NCH = GCS_NCH
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire gcs_access_t acc,
  input wire logic [NCH-1:0] irq_n,
  input wire logic [NCH-1:0] tx_line,
  input wire logic [NCH-1:0] frac_clk,
  input wire logic [7:0] rd_data_q,
  input wire logic ext_addr_q,
  input wire logic [7:0] global_cmd_q,
  input wire logic global_cmd_valid_q,
  input wire logic [NCH-1:0] transmitter_off_q,
  input wire logic [NCH-1:0] launch_q,
  input wire logic [NCH-1:0] start_seen_q,
  input wire logic [NCH-1:0] gpio_clk_q,
  input wire logic [NCH-1:0] gpio_oe_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // a write lands on the broadcast location; spi in extended mode cannot
  wire glb = acc.valid && acc.write && (acc.i2c_mode ? acc.i2c_addr == 7'h1f
             : !ext_addr_q && acc.cmd[4:0] == 5'h1f);
  wire cfg_wr = acc.valid && acc.write && acc.i2c_mode
                && acc.i2c_addr == 7'h20 && acc.wdata[4];

  a_ext_set: assert property (
    glb && acc.wdata == 8'hce |=> ext_addr_q)
    else $error("extended flag not set");
  a_ext_clear: assert property (
    glb && acc.wdata == 8'hcd |=> !ext_addr_q)
    else $error("extended flag not cleared");
  a_ext_hold: assert property (
    !(glb && (acc.wdata == 8'hce || acc.wdata == 8'hcd))
    |=> $stable(ext_addr_q)) else $error("extended flag moved");
  a_glb_echo: assert property (
    glb |=> global_cmd_valid_q && global_cmd_q == $past(acc.wdata))
    else $error("global byte not delivered");
  a_glb_only: assert property (
    !glb |=> !global_cmd_valid_q) else $error("stray global command");
  a_irq_read: assert property (
    acc.valid && !acc.write && acc.i2c_mode && acc.i2c_addr == 7'h1f
    |=> rd_data_q == {4'h0, $past(irq_n)}) else $error("bad irq summary");
  a_cfg_off: assert property (
    cfg_wr |=> transmitter_off_q[$past(acc.i2c_chan)])
    else $error("sync enable did not hold transmitter");
  a_launch_on: assert property (
    (launch_q & transmitter_off_q) == '0)
    else $error("launch left transmitter off");
  a_launch_held: assert property (
    |launch_q |-> (launch_q & ~$past(transmitter_off_q)) == '0)
    else $error("launch without held transmitter");
  a_start_edge: assert property (
    |($past(tx_line) & ~tx_line) |-> ##[0:2] |start_seen_q)
    else $error("start edge missed");
  a_gpio_copy: assert property (
    $stable(gpio_oe_q) |-> gpio_clk_q == ($past(frac_clk) & gpio_oe_q))
    else $error("gpio clock copy wrong");
endmodule : gcs_top_sva

bind gcs_top gcs_top_sva #(.NCH(NCH)) u_sva (
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .acc(acc),
  .irq_n(irq_n),
  .tx_line(tx_line),
  .frac_clk(frac_clk),
  .rd_data_q(rd_data_q),
  .ext_addr_q(ext_addr_q),
  .global_cmd_q(global_cmd_q),
  .global_cmd_valid_q(global_cmd_valid_q),
  .transmitter_off_q(transmitter_off_q),
  .launch_q(launch_q),
  .start_seen_q(start_seen_q),
  .gpio_clk_q(gpio_clk_q),
  .gpio_oe_q(gpio_oe_q)
);

// ==== logic/gcs_delay_cnt.sv ====
// launch delay down-counter on ref_clk, stepped by the channel bit-interval tick
`timescale 1ns/100ps
module gcs_delay_cnt
  import gcs_pkg::*;
#(
  parameter int W = GCS_DLY_W
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic bit_tick,
  output logic expired
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic busy_q;
  logic busy_d;
  logic expired_d;
  wire logic last_tick;

  // the count reaching zero on a tick ends the wait
  assign last_tick = busy_q && bit_tick && (cnt_q == W'(1));

  // a load of zero expires at once; otherwise one tick per bit interval
  always_comb
  begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    expired_d = 1'b0;
    if (load)
    begin
      cnt_d = load_val;
      busy_d = (load_val != '0);
      expired_d = (load_val == '0);
    end
    else if (busy_q && bit_tick)
    begin
      cnt_d = cnt_q - W'(1);
      busy_d = !last_tick;
      expired_d = last_tick;
    end
  end

  // counter state
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      expired <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      expired <= expired_d;
    end
  end

endmodule : gcs_delay_cnt

// ==== logic/gcs_pkg.sv ====
// shared constants, types and helpers of the global command / tx sync block
package gcs_pkg;

  // channel count and widths
  localparam int GCS_NCH = 4;
  localparam int GCS_DLY_W = 16;

  // internal register addresses (8-bit internal address space)
  localparam logic [7:0] GCS_ADDR_GLOBAL = 8'h1f;
  localparam logic [7:0] GCS_ADDR_SYNC_CFG = 8'h20;
  localparam logic [7:0] GCS_ADDR_DLY_LO = 8'h21;
  localparam logic [7:0] GCS_ADDR_DLY_HI = 8'h22;
  localparam logic [7:0] GCS_ADDR_TMR_LO = 8'h23;
  localparam logic [7:0] GCS_ADDR_TMR_HI = 8'h24;
  localparam logic [7:0] GCS_ADDR_REV = 8'h25;

  // global command codes
  localparam logic [7:0] GCS_CMD_EXT_ON = 8'hce;
  localparam logic [7:0] GCS_CMD_EXT_OFF = 8'hcd;
  localparam logic [3:0] GCS_CMD_TRIG_HI = 4'he;

  // address formation prefixes for the spi command byte and the i2c address
  localparam logic [3:0] GCS_EXT_PREFIX = 4'h2;
  localparam logic [2:0] GCS_STD_PREFIX = 3'h0;
  localparam logic [0:0] GCS_I2C_PREFIX = 1'h0;

  // reset values and fill patterns
  localparam logic [7:0] GCS_RST_BYTE = 8'h00;
  localparam logic [3:0] GCS_IRQ_PAD = 4'h0;
  localparam logic [3:0] GCS_IRQ_IDLE_N = 4'hf;
  localparam logic [GCS_DLY_W-1:0] GCS_DLY_ZERO = 16'h0000;

  // decoded access from the serial front end (spi or i2c)
  typedef struct packed {
    logic valid;
    logic write;
    logic i2c_mode;
    logic [1:0] i2c_chan;
    logic [6:0] i2c_addr;
    logic [7:0] cmd;
    logic [7:0] wdata;
  } gcs_access_t;

  // per-channel sync configuration, laid out as the register byte
  typedef struct packed {
    logic sysclk_pin_route;
    logic auto_tx_shutoff;
    logic delayed_launch_en;
    logic sync_launch_en;
    logic [3:0] launch_cmd_select;
  } gcs_sync_cfg_t;

  // per-channel launch sequencing
  typedef enum logic [2:0] {
    GCS_ST_RUN = 3'b001,
    GCS_ST_ARMED = 3'b010,
    GCS_ST_DELAY = 3'b100
  } gcs_state_t;

  // internal address from an spi command byte
  function automatic logic [7:0] gcs_spi_addr(input logic ext,
                                              input logic [7:0] cmd);
    gcs_spi_addr = ext ? {GCS_EXT_PREFIX, cmd[3:0]}
                       : {GCS_STD_PREFIX, cmd[4:0]};
  endfunction : gcs_spi_addr

endpackage : gcs_pkg

// ==== logic/gcs_top.sv ====
// global command decoder and per-channel transmitter launch control
`timescale 1ns/100ps
module gcs_top
  import gcs_pkg::*;
#(
  parameter int NCH = GCS_NCH,
  parameter int DLY_W = GCS_DLY_W,
  parameter logic [7:0] REVISION = 8'h5a // arbitrary value
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire gcs_access_t acc,
  input wire logic [NCH-1:0] irq_n,
  input wire logic [NCH-1:0] bit_tick,
  input wire logic [NCH-1:0] queue_has_data,
  input wire logic [NCH-1:0] tx_idle,
  input wire logic [NCH-1:0] tx_line,
  input wire logic [NCH-1:0] frac_clk,
  output logic [7:0] rd_data_q,
  output logic rd_valid_q,
  output logic ext_addr_q,
  output logic [7:0] global_cmd_q,
  output logic global_cmd_valid_q,
  output logic [NCH-1:0] transmitter_off_q,
  output logic [NCH-1:0] launch_q,
  output logic [NCH-1:0] start_seen_q,
  output logic [NCH-1:0] gpio_clk_q,
  output logic [NCH-1:0] gpio_oe_q
);

  // extended addressing flag
  logic ext_q;
  logic ext_d;

  // per-channel register storage
  gcs_sync_cfg_t cfg_q [NCH];
  logic [7:0] dly_lo_q [NCH];
  logic [7:0] dly_hi_q [NCH];
  logic [7:0] tmr_lo_q [NCH];
  logic [7:0] tmr_hi_q [NCH];

  // per-channel launch state
  gcs_state_t state_q [NCH];
  gcs_state_t state_d [NCH];
  logic [NCH-1:0] txoff_d;
  logic [NCH-1:0] launch_d;
  logic [NCH-1:0] sent_q;
  logic [NCH-1:0] sent_d;
  logic [NCH-1:0] tx_line_q;
  logic [NCH-1:0] dly_load;
  logic [NCH-1:0] dly_expired;

  // read path
  logic [7:0] rd_mux;

  // address decode of the current access
  wire logic [1:0] acc_chan;
  wire logic [7:0] acc_addr;
  wire logic acc_wr;
  wire logic acc_rd;
  wire logic glob_wr;
  wire logic [7:0] glob_byte;
  wire logic is_trig;
  wire logic [3:0] trig_num;
  wire gcs_sync_cfg_t wr_cfg;

  // spi: bit 7 w/r, bits 6:5 channel, bits 4:0 address
  assign acc_chan = acc.i2c_mode ? acc.i2c_chan : acc.cmd[6:5];
  // spi forms the address from the flag, i2c uses its wide field
  assign acc_addr = acc.i2c_mode ? {GCS_I2C_PREFIX, acc.i2c_addr}
                                 : gcs_spi_addr(ext_q, acc.cmd);
  assign acc_wr = acc.valid && acc.write;
  assign acc_rd = acc.valid && !acc.write;

  // a write to the global location goes to every channel at once
  assign glob_wr = acc_wr && (acc_addr == GCS_ADDR_GLOBAL);
  assign glob_byte = acc.wdata;

  // trigger commands occupy the 0xe0..0xef block
  assign is_trig = glob_wr && (glob_byte[7:4] == GCS_CMD_TRIG_HI);
  assign trig_num = glob_byte[3:0];
  // write data seen as a sync configuration byte
  assign wr_cfg = gcs_sync_cfg_t'(acc.wdata);

  // extended flag: only the two codes touch it; set wins if both
  always_comb
  begin
    ext_d = ext_q;
    if (glob_wr && (glob_byte == GCS_CMD_EXT_OFF))
    begin
      ext_d = 1'b0;
    end
    if (glob_wr && (glob_byte == GCS_CMD_EXT_ON))
    begin
      ext_d = 1'b1;
    end
  end

  // flag and broadcast strobe
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_q <= 1'b0;
      global_cmd_q <= GCS_RST_BYTE;
      global_cmd_valid_q <= 1'b0;
    end
    else
    begin
      ext_q <= ext_d;
      global_cmd_valid_q <= glob_wr;
      if (glob_wr)
      begin
        global_cmd_q <= glob_byte;
      end
    end
  end

  assign ext_addr_q = ext_q;

  // read multiplexer; the global location reads back the irq summary
  // since the command byte itself is write-only
  always_comb
  begin
    unique case (acc_addr)
      GCS_ADDR_GLOBAL: rd_mux = {GCS_IRQ_PAD, irq_n};
      GCS_ADDR_SYNC_CFG: rd_mux = cfg_q[acc_chan];
      GCS_ADDR_DLY_LO: rd_mux = dly_lo_q[acc_chan];
      GCS_ADDR_DLY_HI: rd_mux = dly_hi_q[acc_chan];
      GCS_ADDR_TMR_LO: rd_mux = tmr_lo_q[acc_chan];
      GCS_ADDR_TMR_HI: rd_mux = tmr_hi_q[acc_chan];
      GCS_ADDR_REV: rd_mux = REVISION;
      default: rd_mux = GCS_RST_BYTE;
    endcase
  end

  // read answer registered one cycle after the access
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data_q <= GCS_RST_BYTE;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      rd_valid_q <= acc_rd;
      if (acc_rd)
      begin
        rd_data_q <= rd_mux;
      end
    end
  end

  // per-channel registers and launch sequencing
  for (genvar c = 0; c < NCH; c++)
  begin : g_chan
    wire logic sel_wr;
    wire logic cfg_wr;
    wire logic [DLY_W-1:0] dly_val;
    wire logic trig_hit;
    wire logic queue_done;
    wire logic start_edge;

    // writes reach one channel; only the global location reaches all
    assign sel_wr = acc_wr && (acc_chan == 2'(c));
    assign cfg_wr = sel_wr && (acc_addr == GCS_ADDR_SYNC_CFG);
    // sixteen-bit delay from the two bytes
    assign dly_val = {dly_hi_q[c], dly_lo_q[c]};
    // trigger counts only when its number matches and sync is on
    assign trig_hit = is_trig && cfg_q[c].sync_launch_en
                      && (trig_num == cfg_q[c].launch_cmd_select);
    assign queue_done = !queue_has_data[c] && tx_idle[c];
    // start bit begins on the high-to-low step of the tx line
    assign start_edge = tx_line_q[c] && !tx_line[c];

    // register writes for this channel
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        cfg_q[c] <= gcs_sync_cfg_t'(GCS_RST_BYTE);
        dly_lo_q[c] <= GCS_RST_BYTE;
        dly_hi_q[c] <= GCS_RST_BYTE;
        tmr_lo_q[c] <= GCS_RST_BYTE;
        tmr_hi_q[c] <= GCS_RST_BYTE;
      end
      else if (sel_wr)
      begin
        if (acc_addr == GCS_ADDR_SYNC_CFG)
        begin
          cfg_q[c] <= gcs_sync_cfg_t'(acc.wdata);
        end
        if (acc_addr == GCS_ADDR_DLY_LO)
        begin
          dly_lo_q[c] <= acc.wdata;
        end
        if (acc_addr == GCS_ADDR_DLY_HI)
        begin
          dly_hi_q[c] <= acc.wdata;
        end
        if (acc_addr == GCS_ADDR_TMR_LO)
        begin
          tmr_lo_q[c] <= acc.wdata;
        end
        if (acc_addr == GCS_ADDR_TMR_HI)
        begin
          tmr_hi_q[c] <= acc.wdata;
        end
      end
    end

    // launch sequencing; a trigger with an empty queue is dropped,
    // because there would be nothing for the start bit to carry
    always_comb
    begin
      state_d[c] = state_q[c];
      txoff_d[c] = transmitter_off_q[c];
      launch_d[c] = 1'b0;
      sent_d[c] = sent_q[c] || start_edge;
      dly_load[c] = 1'b0;
      unique case (state_q[c])
        GCS_ST_RUN:
        begin
          // empty after real traffic: shut off and wait for trigger
          if (cfg_q[c].auto_tx_shutoff && sent_q[c] && queue_done)
          begin
            txoff_d[c] = 1'b1;
            sent_d[c] = start_edge; // a fresh start bit wins the clear
            state_d[c] = GCS_ST_ARMED;
          end
        end
        GCS_ST_ARMED:
        begin
          if (trig_hit && queue_has_data[c])
          begin
            if (cfg_q[c].delayed_launch_en)
            begin
              dly_load[c] = 1'b1;
              state_d[c] = GCS_ST_DELAY;
            end
            else
            begin
              txoff_d[c] = 1'b0;
              launch_d[c] = 1'b1;
              sent_d[c] = 1'b0;
              state_d[c] = GCS_ST_RUN;
            end
          end
        end
        GCS_ST_DELAY:
        begin
          if (dly_expired[c])
          begin
            txoff_d[c] = 1'b0;
            launch_d[c] = 1'b1;
            sent_d[c] = 1'b0;
            state_d[c] = GCS_ST_RUN;
          end
        end
      endcase
      // sync launch written high holds the transmitter off at once
      if (cfg_wr && wr_cfg.sync_launch_en)
      begin
        txoff_d[c] = 1'b1;
        launch_d[c] = 1'b0;
        state_d[c] = GCS_ST_ARMED;
      end
      else if (cfg_wr && !wr_cfg.auto_tx_shutoff)
      begin
        // both modes cleared: hand the transmitter back
        txoff_d[c] = 1'b0;
        state_d[c] = GCS_ST_RUN;
      end
    end

    // delay countdown on the channel bit-interval tick
    gcs_delay_cnt #(
      .W(DLY_W)
    ) u_dly (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .load(dly_load[c]),
      .load_val(dly_val),
      .bit_tick(bit_tick[c]),
      .expired(dly_expired[c])
    );

    // launch state and pin outputs
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        state_q[c] <= GCS_ST_RUN;
        transmitter_off_q[c] <= 1'b0;
        launch_q[c] <= 1'b0;
        sent_q[c] <= 1'b0;
        tx_line_q[c] <= 1'b1;
        start_seen_q[c] <= 1'b0;
        gpio_clk_q[c] <= 1'b0;
        gpio_oe_q[c] <= 1'b0;
      end
      else
      begin
        state_q[c] <= state_d[c];
        transmitter_off_q[c] <= txoff_d[c];
        launch_q[c] <= launch_d[c];
        sent_q[c] <= sent_d[c];
        tx_line_q[c] <= tx_line[c];
        start_seen_q[c] <= start_edge;
        // registered copy: one ref_clk of latency, and frac_clk
        // must be slower than half ref_clk to survive the sampling
        gpio_clk_q[c] <= cfg_q[c].sysclk_pin_route && frac_clk[c];
        gpio_oe_q[c] <= cfg_q[c].sysclk_pin_route;
      end
    end
  end

endmodule : gcs_top
